// ---- verilog/fpl_loop_config.sv ----
// Configuration registers for the first phase loop: feedback divider, charge pump, receivers.
// Assumes a serial port front end that presents byte writes and reads on a 16-bit address.
`timescale 1ns/1ps
`include "fpl_cfg.svh"

module fpl_loop_config #(
    parameter int ADDR_W = 16,
    parameter int FB_W   = 10
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 resetn,
    // Register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    output logic                      update_pulse,
    // Active loop controls
    output logic      [FB_W-1:0]      loop_feedback_divider_value,
    output logic      [FB_W-1:0]      loop_feedback_divide_ratio,
    output logic                      force_holdover,
    output logic      [6:0]           charge_pump_current,
    output logic                      auto_holdover_disable,
    output fpl_pkg::fpl_cp_mode_t     charge_pump_mode,
    output logic                      charge_pump_tristate,
    // Active receiver controls
    output logic                      freq_detector_pd_en,
    output logic                      second_reference_input_diff,
    output logic                      first_reference_input_diff,
    output logic                      second_reference_input_en,
    output logic                      first_reference_input_en,
    output logic                      oscillator_input_pd_ctrl,
    output logic                      oscillator_input_pin_neg_sel,
    output logic                      oscillator_input_diff
);

    // Buffer registers, written by the host
    logic [7:0] buf_fb_low_q;
    logic [7:0] buf_fb_high_q;
    logic [7:0] buf_cp_cur_q;
    logic [7:0] buf_cp_mode_q;
    logic [7:0] buf_rx_q;
    // Active registers, loaded only on update
    logic [7:0] act_fb_low_q;
    logic [7:0] act_fb_high_q;
    logic [7:0] act_cp_cur_q;
    logic [7:0] act_cp_mode_q;
    logic [7:0] act_rx_q;
    logic       update_q;

    wire sel_update = (reg_addr == `FPL_ADDR_UPDATE);
    wire sel_fb_low = (reg_addr == `FPL_ADDR_FB_LOW);
    wire sel_fb_hi  = (reg_addr == `FPL_ADDR_FB_HIGH);
    wire sel_cp_cur = (reg_addr == `FPL_ADDR_CP_CURRENT);
    wire sel_cp_mod = (reg_addr == `FPL_ADDR_CP_MODE);
    wire sel_rx     = (reg_addr == `FPL_ADDR_RX_CTRL);

    wire do_update  = reg_wr && sel_update && reg_wdata[`FPL_UPDATE_BIT];

    // Reserved bits are masked at write so they can never be set
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            buf_fb_low_q  <= `FPL_RST_FB_LOW;
            buf_fb_high_q <= `FPL_RST_FB_HIGH;
            buf_cp_cur_q  <= `FPL_RST_CP_CURRENT;
            buf_cp_mode_q <= `FPL_RST_CP_MODE;
            buf_rx_q      <= `FPL_RST_RX_CTRL;
        end else if (reg_wr) begin
            if (sel_fb_low) begin
                buf_fb_low_q <= reg_wdata;
            end else if (sel_fb_hi) begin
                buf_fb_high_q <= reg_wdata & `FPL_FB_HIGH_MASK;
            end else if (sel_cp_cur) begin
                buf_cp_cur_q <= reg_wdata;
            end else if (sel_cp_mod) begin
                buf_cp_mode_q <= reg_wdata & `FPL_CP_MODE_MASK;
            end else if (sel_rx) begin
                buf_rx_q <= reg_wdata;
            end
        end
    end

    // Update is a write-one strobe, so the bit never holds a one to clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            act_fb_low_q  <= `FPL_RST_FB_LOW;
            act_fb_high_q <= `FPL_RST_FB_HIGH;
            act_cp_cur_q  <= `FPL_RST_CP_CURRENT;
            act_cp_mode_q <= `FPL_RST_CP_MODE;
            act_rx_q      <= `FPL_RST_RX_CTRL;
            update_q      <= 1'b0;
        end else begin
            update_q <= do_update;
            if (do_update) begin
                act_fb_low_q  <= buf_fb_low_q;
                act_fb_high_q <= buf_fb_high_q;
                act_cp_cur_q  <= buf_cp_cur_q;
                act_cp_mode_q <= buf_cp_mode_q;
                act_rx_q      <= buf_rx_q;
            end
        end
    end

    // Reads show the buffer, i.e. the value last written
    always_comb begin
        reg_rdata = 8'h00;
        if (reg_rd) begin
            if (sel_fb_low) begin
                reg_rdata = buf_fb_low_q;
            end else if (sel_fb_hi) begin
                reg_rdata = buf_fb_high_q;
            end else if (sel_cp_cur) begin
                reg_rdata = buf_cp_cur_q;
            end else if (sel_cp_mod) begin
                reg_rdata = buf_cp_mode_q;
            end else if (sel_rx) begin
                reg_rdata = buf_rx_q;
            end
        end
    end

    assign update_pulse = update_q;

    // Zero would be a meaningless ratio, so it is folded onto one
    wire [FB_W-1:0] fb_raw = {act_fb_high_q[1:0], act_fb_low_q};
    assign loop_feedback_divider_value = fb_raw;
    assign loop_feedback_divide_ratio  = (fb_raw == '0) ? FB_W'(1) : fb_raw;

    assign force_holdover        = act_cp_cur_q[`FPL_FORCE_HOLD_BIT];
    assign charge_pump_current   = act_cp_cur_q[6:0];
    assign auto_holdover_disable = act_cp_mode_q[`FPL_AUTO_HOLD_DIS_BIT];
    assign charge_pump_mode      = fpl_pkg::fpl_cp_mode_t'(act_cp_mode_q[1:0]);
    // Forced holdover overrides the mode field
    assign charge_pump_tristate  = force_holdover ||
                                   (charge_pump_mode == fpl_pkg::FPL_CP_TRISTATE);

    assign freq_detector_pd_en          = act_rx_q[`FPL_FD_PD_BIT];
    assign second_reference_input_diff  = act_rx_q[`FPL_REF2_DIFF_BIT];
    assign first_reference_input_diff   = act_rx_q[`FPL_REF1_DIFF_BIT];
    assign second_reference_input_en    = act_rx_q[`FPL_REF2_EN_BIT];
    assign first_reference_input_en     = act_rx_q[`FPL_REF1_EN_BIT];
    assign oscillator_input_pd_ctrl     = act_rx_q[`FPL_OSC_PD_CTRL_BIT];
    // Pin choice only matters in single-ended mode
    assign oscillator_input_pin_neg_sel = act_rx_q[`FPL_OSC_NEG_SEL_BIT] &&
                                          !act_rx_q[`FPL_OSC_DIFF_BIT];
    assign oscillator_input_diff        = act_rx_q[`FPL_OSC_DIFF_BIT];

endmodule : fpl_loop_config

// ---- verilog/fpl_cfg.svh ----
// Register map constants for the first phase loop configuration slice.
// Assumes an 8-bit register port with a 16-bit address, as the serial port decodes it.
`ifndef FPL_CFG_SVH
`define FPL_CFG_SVH
`define FPL_ADDR_UPDATE      16'h000F
`define FPL_ADDR_FB_LOW      16'h0104
`define FPL_ADDR_FB_HIGH     16'h0105
`define FPL_ADDR_CP_CURRENT  16'h0106
`define FPL_ADDR_CP_MODE     16'h0107
`define FPL_ADDR_RX_CTRL     16'h0108
`define FPL_UPDATE_BIT       0
`define FPL_FORCE_HOLD_BIT   7
`define FPL_AUTO_HOLD_DIS_BIT 5
`define FPL_FD_PD_BIT        7
`define FPL_REF2_DIFF_BIT    6
`define FPL_REF1_DIFF_BIT    5
`define FPL_REF2_EN_BIT      4
`define FPL_REF1_EN_BIT      3
`define FPL_OSC_PD_CTRL_BIT  2
`define FPL_OSC_NEG_SEL_BIT  1
`define FPL_OSC_DIFF_BIT     0
`define FPL_FB_HIGH_MASK     8'h03
`define FPL_CP_MODE_MASK     8'h23
`define FPL_RST_FB_LOW       8'h00
`define FPL_RST_FB_HIGH      8'h00
`define FPL_RST_CP_CURRENT   8'h00
`define FPL_RST_CP_MODE      8'h00
`define FPL_RST_RX_CTRL      8'h00
`endif

// ---- verilog/fpl_pkg.sv ----
// Types for the first phase loop configuration slice.
// Assumes nothing beyond the matching constant header.
package fpl_pkg;
    typedef enum logic [1:0] {
        FPL_CP_TRISTATE,
        FPL_CP_PUMP_DOWN,
        FPL_CP_PUMP_UP,
        FPL_CP_NORMAL
    } fpl_cp_mode_t;
endpackage : fpl_pkg

// ---- verif/fpl_loop_config_chk.sv ----
// Checker for the first phase loop configuration slice.
// Assumes it is bound to the design and sees only its ports.
`timescale 1ns/1ps
module fpl_loop_config_chk #(
    parameter int ADDR_W = 16,
    parameter int FB_W   = 10
) (
    // Clock, reset and register port
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata,
    input wire logic              update_pulse,
    // Active controls
    input wire logic [FB_W-1:0]   loop_feedback_divider_value,
    input wire logic [FB_W-1:0]   loop_feedback_divide_ratio,
    input wire logic              force_holdover,
    input wire fpl_pkg::fpl_cp_mode_t charge_pump_mode,
    input wire logic              charge_pump_tristate,
    input wire logic              oscillator_input_pin_neg_sel,
    input wire logic              oscillator_input_diff
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire upd_w = reg_wr && reg_addr == 16'h000F && reg_wdata[0];
    chk_pulse_after: assert property (upd_w |=> update_pulse)
        else $error("update pulse missing");
    chk_pulse_cause: assert property (update_pulse |-> $past(upd_w))
        else $error("update pulse without update write");
    // The divider value and pump mode must not drift between updates, or the loop would retune mid-write
    chk_active_hold: assert property (!upd_w |=> $stable(loop_feedback_divider_value)
        && $stable(charge_pump_mode)) else $error("active control changed without update");
    chk_fb_copy: assert property ((reg_wr && reg_addr == 16'h0104) ##1 upd_w
        |=> loop_feedback_divider_value[7:0] == $past(reg_wdata, 2)) else $error("divider low");
    chk_ratio_floor: assert property (loop_feedback_divide_ratio ==
        ((loop_feedback_divider_value > 1) ? loop_feedback_divider_value : FB_W'(1)))
        else $error("divide ratio wrong");
    chk_tristate_or: assert property (charge_pump_tristate == (force_holdover ||
        charge_pump_mode == fpl_pkg::FPL_CP_TRISTATE)) else $error("tristate wrong");
    chk_rd_idle: assert property (!reg_rd |-> reg_rdata == 8'h00)
        else $error("read data while idle");
    chk_rsvd_zero: assert property (reg_rd && reg_addr == 16'h0107 |->
        (reg_rdata & 8'hDC) == 8'h00) else $error("reserved bits read nonzero");
    chk_neg_sel: assert property (oscillator_input_pin_neg_sel |-> !oscillator_input_diff)
        else $error("negative pin select in differential mode");
endmodule : fpl_loop_config_chk

// ---- verif/fpl_loop_config_bench.sv ----
// Bench for the loop configuration slice: random writes, readback, update, outputs.
// Assumes the design, package and checker are compiled before it.
`timescale 1ns/1ps
module fpl_loop_config_bench;
    logic        core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, lf = 8'h4C;
    logic [7:0]  buf_q [5] = '{default: 8'h00};
    logic [7:0]  act_q [5] = '{default: 8'h00};
    logic [7:0]  msk [5] = '{8'hFF, 8'h03, 8'hFF, 8'h23, 8'hFF};
    wire  [7:0]  rdata;
    wire  [39:0] outs;
    int          fails = 0, samples_checked = 0;
    always #12.5 core_clk = ~core_clk;
    fpl_loop_config DUT (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata),
        .update_pulse(), .loop_feedback_divider_value(outs[39:30]),
        .loop_feedback_divide_ratio(outs[29:20]), .force_holdover(outs[19]),
        .charge_pump_current(outs[18:12]), .auto_holdover_disable(outs[11]),
        .charge_pump_mode(outs[10:9]), .charge_pump_tristate(outs[8]),
        .freq_detector_pd_en(outs[7]), .second_reference_input_diff(outs[6]),
        .first_reference_input_diff(outs[5]), .second_reference_input_en(outs[4]),
        .first_reference_input_en(outs[3]), .oscillator_input_pd_ctrl(outs[2]),
        .oscillator_input_pin_neg_sel(outs[1]), .oscillator_input_diff(outs[0]));
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nx
    function automatic logic [39:0] exp_out();
        logic [9:0] v;
        v = {act_q[1][1:0], act_q[0]};
        return {v, (v > 10'h001) ? v : 10'h001, act_q[2], act_q[3][5], act_q[3][1:0],
            act_q[2][7] | (act_q[3][1:0] == 2'h0), act_q[4][7:2],
            act_q[4][1] & ~act_q[4][0], act_q[4][0]};
    endfunction : exp_out
    task automatic cmp(input logic [39:0] got, input logic [39:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp
    // Reads are checked inside the cycle, since read data is only valid while selected
    task automatic op(input logic w, input logic [15:0] a, input logic [7:0] d, e);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        #1;
        if (!w) cmp({32'h0, rdata}, {32'h0, e}, "readback");
        @(negedge core_clk);
    endtask : op
    task automatic wreg(input int i, input int it);
        logic [7:0] d;
        lf = nx(lf);
        d = lf;
        if (i < 2 && it < 3) d = (it == 2) ? 8'hFF : ((i == 0) ? 8'(it) : 8'h00);
        if (i == 3) d[1:0] = 2'(it);
        op(1'b1, 16'(16'h0104 + i), d, 8'h00);
        buf_q[i] = d & msk[i];
    endtask : wreg
    task automatic final_report();
        $display("samples_checked %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #100000;
        fails++;
        final_report();
    end
    initial begin
        repeat (5) @(negedge core_clk);
        resetn = 1;
        cmp(outs, exp_out(), "reset outputs");
        for (int it = 0; it < 40; it++) begin
            for (int i = 4; i > 0; i--) wreg(i, it);
            lf = nx(lf);
            op(1'b1, 16'h0110, lf, 8'h00);
            op(1'b1, 16'h000F, {lf[7:1], 1'b0}, 8'h00);
            cmp(outs, exp_out(), "held before update");
            wreg(0, it);
            op(1'b1, 16'h000F, 8'h01, 8'h00);
            act_q = buf_q;
            cmp(outs, exp_out(), "active");
            for (int i = 0; i < 5; i++) op(1'b0, 16'(16'h0104 + i), 8'h00, buf_q[i]);
            op(1'b0, 16'h0110, 8'h00, 8'h00);
            op(1'b0, 16'h000F, 8'h00, 8'h00);
        end
        reg_rd = 0;
        @(negedge core_clk);
        final_report();
    end
endmodule : fpl_loop_config_bench
bind fpl_loop_config fpl_loop_config_chk #(.ADDR_W(ADDR_W), .FB_W(FB_W)) u_chk (.*);
